/* src/compare_match_interval_timer.sv */
`timescale 1ns/1ps
// four-channel compare-match interval timer with plain register ports
// Summary of operation
// - counting starts when run bit written one
// - counter equal constant sets match flag
// - counter read after status read clears flag
// - on match counter reloads zero, keeps counting
// - counter writable while counting, continues onward
// - run cleared freezes count; resume from held
// - flag rises one clock after reload
// - interrupt equals flag and enable
// - stop mode clears flag, run, counter, irq
// - stop mode keeps other control, prescale bits
// - only reset leaves stop; clears prescale
// - reset clears control, prescale, counter, irq
// - reset loads match constant with all ones
// - reserved bits read back as zero
// - 3-bit field selects base divided 2^n
// - four independent channels, own registers each
// - counter reads do not disturb counting
module compare_match_interval_timer
  import interval_timer_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_sys_stop,
  input wire logic [NUM_CH-1:0] i_cnt_wr,
  input wire logic [NUM_CH-1:0] i_const_wr,
  input wire logic [NUM_CH-1:0] i_cs_wr,
  input wire logic [NUM_CH-1:0] i_ps_wr,
  input wire logic [NUM_CH-1:0] i_cnt_rd,
  input wire logic [NUM_CH-1:0] i_cs_rd,
  input wire logic [CNT_W-1:0] i_wdata,
  output logic [CNT_W-1:0] o_up_counter_value [NUM_CH],
  output logic [CNT_W-1:0] o_match_constant [NUM_CH],
  output logic [7:0] o_timer_ctrl_status [NUM_CH],
  output logic [7:0] o_prescale_select_reg [NUM_CH],
  output logic o_timer_irq_ch0,
  output logic o_timer_irq_ch1,
  output logic o_timer_irq_ch2,
  output logic o_timer_irq_ch3,
  output logic o_sys_stopped
);
  logic [7:0] tick;
  logic stop_q;
  logic stop_d;
  logic [NUM_CH-1:0] irq_q;
  logic [NUM_CH-1:0] irq_d;

  // picks the tick that matches a prescale code
  function automatic logic sel_tick(input logic [PS_W-1:0] sel, input logic [7:0] t);
    sel_tick = t[sel];
  endfunction : sel_tick

  // assembles the readable control/status byte; reserved bits are zero
  function automatic logic [7:0] cs_image(input logic f, input logic e, input logic r);
    cs_image = CS_RESET;
    cs_image[CS_FLAG_BIT] = f;
    cs_image[CS_IEN_BIT] = e;
    cs_image[CS_RUN_BIT] = r;
  endfunction : cs_image

  prescale_tick u_prescale (
    .i_mclk (i_mclk),
    .i_rst_b(i_rst_b),
    .o_tick (tick)
  );

  // stop mode is sticky; only the reset input ends it
  always_comb begin
    stop_d = stop_q | i_sys_stop;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= stop_d;
    end
  end

  assign o_sys_stopped = stop_q;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    // control group
    logic [CNT_W-1:0] const_q;
    logic [CNT_W-1:0] const_d;
    logic ien_q;
    logic ien_d;
    logic run_q;
    logic run_d;
    logic [PS_W-1:0] ps_q;
    logic [PS_W-1:0] ps_d;

    // counter group
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic hit_q;
    logic hit_d;
    logic step;
    logic match;

    // flag group
    logic flag_q;
    logic flag_d;
    logic armed_q;
    logic armed_d;

    // readable images
    logic [7:0] cs_img_q;
    logic [7:0] cs_img_d;
    logic [7:0] ps_img_q;
    logic [7:0] ps_img_d;

    // control writes; run gates all stepping
    always_comb begin
      const_d = const_q;
      ien_d = ien_q;
      run_d = run_q;
      ps_d = ps_q;
      if (i_cs_wr[c]) begin
        ien_d = i_wdata[CS_IEN_BIT];
        run_d = i_wdata[CS_RUN_BIT];
      end
      if (i_ps_wr[c]) begin
        ps_d = i_wdata[PS_W-1:0];
      end
      if (i_const_wr[c]) begin
        const_d = i_wdata;
      end
      // stop mode drops run but keeps the rest of the control state
      if (stop_d) begin
        run_d = 1'b0;
        ien_d = ien_q;
        ps_d = ps_q;
        const_d = const_q;
      end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        const_q <= CONST_RESET;
        ien_q <= 1'b0;
        run_q <= 1'b0;
        ps_q <= PS_RESET;
      end else begin
        const_q <= const_d;
        ien_q <= ien_d;
        run_q <= run_d;
        ps_q <= ps_d;
      end
    end

    // counter: host write wins over stepping, then reload on match
    always_comb begin
      step = run_q && sel_tick(ps_q, tick);
      match = (cnt_q == const_q);
      cnt_d = cnt_q;
      hit_d = 1'b0;
      if (i_cnt_wr[c]) begin
        cnt_d = i_wdata;
      end else if (step && match) begin
        cnt_d = CNT_RESET;
        hit_d = 1'b1;
      end else if (step) begin
        cnt_d = cnt_q + CNT_STEP;
      end
      if (stop_d) begin
        cnt_d = CNT_RESET;
        hit_d = 1'b0;
      end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        cnt_q <= CNT_RESET;
        hit_q <= 1'b0;
      end else begin
        cnt_q <= cnt_d;
        hit_q <= hit_d;
      end
    end

    // a status read arms the clear; only a counter read or stop mode disarms it
    always_comb begin
      flag_d = flag_q;
      armed_d = armed_q;
      if (i_cs_rd[c]) begin
        armed_d = 1'b1;
      end
      if (i_cnt_rd[c] && armed_q) begin
        flag_d = 1'b0;
        armed_d = 1'b0;
      end
      // the flag is raised one clock after the reload; set beats clear
      if (hit_q) begin
        flag_d = 1'b1;
      end
      if (stop_d) begin
        flag_d = 1'b0;
        armed_d = 1'b0;
      end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        flag_q <= 1'b0;
        armed_q <= 1'b0;
      end else begin
        flag_q <= flag_d;
        armed_q <= armed_d;
      end
    end

    // images are registered so every output comes from a flip-flop
    always_comb begin
      cs_img_d = cs_image(flag_d, ien_d, run_d);
      ps_img_d = PS_REG_RESET;
      ps_img_d[PS_W-1:0] = ps_d;
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        cs_img_q <= CS_RESET;
        ps_img_q <= PS_REG_RESET;
      end else begin
        cs_img_q <= cs_img_d;
        ps_img_q <= ps_img_d;
      end
    end

    // irq is registered from the next flag and enable so it tracks flag and enable exactly
    assign irq_d[c] = flag_d && ien_d && !stop_d;

    assign o_up_counter_value[c] = cnt_q;
    assign o_match_constant[c] = const_q;
    assign o_timer_ctrl_status[c] = cs_img_q;
    assign o_prescale_select_reg[c] = ps_img_q;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_q <= '0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign o_timer_irq_ch0 = irq_q[0];
  assign o_timer_irq_ch1 = irq_q[1];
  assign o_timer_irq_ch2 = irq_q[2];
  assign o_timer_irq_ch3 = irq_q[3];
endmodule : compare_match_interval_timer

/* src/interval_timer_pkg.sv */
// constants shared by the four-channel interval timer
package interval_timer_pkg;
  localparam int NUM_CH = 4;
  localparam int CNT_W = 16;
  localparam int PS_W = 3;
  localparam int DIV_W = 7;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CONST_RESET = 16'hffff;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  localparam logic [2:0] PS_RESET = 3'h0;
  localparam logic [6:0] DIV_STEP = 7'h01;
  // control/status byte layout
  localparam int CS_FLAG_BIT = 7;
  localparam int CS_IEN_BIT = 6;
  localparam int CS_RUN_BIT = 4;
  localparam logic [7:0] CS_RESET = 8'h00;
  localparam logic [7:0] PS_REG_RESET = 8'h00;
endpackage : interval_timer_pkg

/* src/prescale_tick.sv */
`timescale 1ns/1ps
// shared free-running divider giving one-cycle ticks at base/2^n
module prescale_tick
  import interval_timer_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  output logic [7:0] o_tick
);
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;

  always_comb begin
    div_d = div_q + DIV_STEP;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // tick n fires once every 2^n cycles; tick 0 every cycle
  assign o_tick[0] = 1'b1;
  for (genvar k = 1; k < 8; k++) begin : g_tick
    assign o_tick[k] = (div_q[k-1:0] == {k{1'b1}});
  end
endmodule : prescale_tick

/* test/tb_top.sv */
// self-checking bench for the interval timer
`timescale 1ns/1ps
module tb_top
  import interval_timer_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_sys_stop = 1'b0;
  logic [23:0] stb = '0;
  logic [15:0] i_wdata = '0;
  logic [15:0] cnt [NUM_CH];
  logic [15:0] cst [NUM_CH];
  logic [7:0] cs [NUM_CH];
  logic [7:0] ps [NUM_CH];
  logic [3:0] irq;
  logic stopped;
  logic [15:0] v;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  compare_match_interval_timer DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_sys_stop(i_sys_stop), .i_cnt_wr(stb[3:0]), .i_const_wr(stb[7:4]),
    .i_cs_wr(stb[11:8]), .i_ps_wr(stb[15:12]), .i_cnt_rd(stb[19:16]),
    .i_cs_rd(stb[23:20]), .i_wdata(i_wdata), .o_up_counter_value(cnt),
    .o_match_constant(cst), .o_timer_ctrl_status(cs), .o_prescale_select_reg(ps),
    .o_timer_irq_ch0(irq[0]), .o_timer_irq_ch1(irq[1]), .o_timer_irq_ch2(irq[2]),
    .o_timer_irq_ch3(irq[3]), .o_sys_stopped(stopped));
  initial forever #50 i_mclk = ~i_mclk;
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n);
    stb = '0;
    repeat (n) @(negedge i_mclk);
  endtask : tick
  // kinds: 0 count, 1 constant, 2 ctrl, 3 prescale writes; 4 count, 5 ctrl reads
  task automatic st(input int k, input int c, input logic [15:0] d);
    i_wdata = d;
    stb = 24'h000001 << (4 * k + c);
    @(negedge i_mclk);
  endtask : st
  task automatic t_reset;
    for (int c = 0; c < NUM_CH; c++) begin
      chk(cnt[c], 16'h0000);
      chk(cst[c], 16'hffff);
      chk({cs[c], ps[c]}, 16'h0000);
    end
    chk({12'h000, irq}, 16'h0000);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_match;
    st(1, 0, 16'h0002);
    st(0, 0, 16'h0000);
    st(2, 0, 16'h0050);
    tick(3);
    chk(cnt[0], 16'h0000);
    chk(cs[0], 8'h50);
    tick(1);
    chk(cs[0], 8'hd0);
    chk({15'h0, irq[0]}, 16'h0001);
    tick(1);
    st(2, 0, 16'h0040);
    tick(3);
    st(5, 0, 16'h0000);
    st(1, 1, 16'h0007);
    chk(cst[1], 16'h0007);
    st(4, 0, 16'h0000);
    chk(cs[0], 8'h40);
    chk({15'h0, irq[0]}, 16'h0000);
    $display("t_match done");
  endtask : t_match
  task automatic t_wr_run;
    st(2, 2, 16'h0010);
    tick(2);
    st(0, 2, 16'h1234);
    chk(cnt[2], 16'h1234);
    tick(1);
    chk(cnt[2], 16'h1235);
    st(2, 2, 16'h0000);
    v = cnt[2];
    tick(3);
    chk(cnt[2], v);
    st(2, 2, 16'h0010);
    tick(1);
    chk(cnt[2], v + 16'h0001);
    $display("t_wr_run done");
  endtask : t_wr_run
  task automatic t_ps;
    st(3, 3, 16'h00fa);
    chk(ps[3], 8'h02);
    st(2, 3, 16'h00bf);
    chk(cs[3], 8'h10);
    tick(40);
    chk(cnt[3], 16'h000a);
    $display("t_ps done");
  endtask : t_ps
  task automatic t_stop;
    st(3, 0, 16'h0005);
    st(2, 0, 16'h0050);
    tick(2);
    i_sys_stop = 1'b1;
    tick(2);
    chk(cnt[0], 16'h0000);
    chk({cs[0], ps[0]}, 16'h4005);
    chk({14'h0, irq[0], stopped}, 16'h0001);
    i_sys_stop = 1'b0;
    st(2, 0, 16'h0050);
    chk(cs[0], 8'h40);
    chk({15'h0, stopped}, 16'h0001);
    i_rst_b = 1'b0;
    tick(1);
    i_rst_b = 1'b1;
    chk({ps[0], 7'h0, stopped}, 16'h0000);
    $display("t_stop done");
  endtask : t_stop
  initial begin
    tick(5);
    i_rst_b = 1'b1;
    t_reset;
    t_match;
    t_wr_run;
    t_ps;
    t_stop;
    tally_and_finish;
  end
endmodule : tb_top
bind compare_match_interval_timer timer_sva u_sva (.*);

/* test/timer_sva.sv */
// port checker for the interval timer, channel 0
`timescale 1ns/1ps
module timer_sva
  import interval_timer_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_sys_stop,
  input wire logic [NUM_CH-1:0] i_cnt_wr,
  input wire logic [NUM_CH-1:0] i_cs_wr,
  input wire logic [NUM_CH-1:0] i_cs_rd,
  input wire logic [NUM_CH-1:0] i_cnt_rd,
  input wire logic [CNT_W-1:0] i_wdata,
  input wire logic [CNT_W-1:0] o_up_counter_value [NUM_CH],
  input wire logic [CNT_W-1:0] o_match_constant [NUM_CH],
  input wire logic [7:0] o_timer_ctrl_status [NUM_CH],
  input wire logic [7:0] o_prescale_select_reg [NUM_CH],
  input wire logic o_timer_irq_ch0
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  wire logic [15:0] cnt = o_up_counter_value[0];
  wire logic [15:0] cst = o_match_constant[0];
  wire logic [7:0] cs = o_timer_ctrl_status[0];
  // only undivided counting is exact per cycle; divided rates hang on divider phase
  wire logic go = cs[4] && o_prescale_select_reg[0][2:0] == 3'h0 && !i_cnt_wr[0]
    && !i_cs_wr[0] && !i_sys_stop;
  a_irq_follows_flag: assert property (o_timer_irq_ch0 == (cs[7] & cs[6]))
    else $error("irq mismatch");
  a_reserved_zero: assert property (
    (cs & 8'h2f) == 8'h00 && o_prescale_select_reg[0][7:3] == 5'h00) else $error("reserved set");
  a_flag_after_reload: assert property ($rose(cs[7]) |-> $past(cnt) == 16'h0000)
    else $error("flag early");
  a_run_off_frozen: assert property (
    !cs[4] && !i_cnt_wr[0] && !i_sys_stop |=> $stable(cnt)) else $error("count moved");
  a_step_by_one: assert property (
    go && cnt != cst |=> cnt == $past(cnt) + 16'h0001) else $error("bad step");
  a_match_reload: assert property (go && cnt == cst |=> cnt == 16'h0000)
    else $error("no reload");
  a_count_write: assert property (
    i_cnt_wr[0] && !i_sys_stop |=> cnt == $past(i_wdata)) else $error("write lost");
  a_read_pair_clear: assert property (
    i_cs_rd[0] ##[1:3] (i_cnt_rd[0] && !cs[4]) |=> !cs[7]) else $error("flag kept");
  cover property ($rose(cs[7]));
  cover property ($rose(o_timer_irq_ch0));
  cover property (i_cs_rd[0] ##1 i_cnt_rd[0]);
endmodule : timer_sva
